/* File: inc/ahs_pkg.sv */
package ahs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_HPOS = 8'h08;
   localparam logic [7:0] OFS_HOFS = 8'h0c;
   localparam logic [7:0] OFS_SPEED = 8'h10;
   localparam logic [7:0] OFS_ACCEL = 8'h14;
   localparam logic [7:0] OFS_REV = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1c;
   localparam logic [7:0] OFS_POS = 8'h20;

   // Control fields (write one to act)
   localparam int CTRL_START = 0;
   localparam int CTRL_SERVO_OFF = 1;

   // Configuration fields
   localparam int CFG_ACTIVE = 0;
   localparam int CFG_SEQ = 1;
   localparam int CFG_DIR = 3;
   localparam int CFG_NC = 4;
   localparam int CFG_UNI = 5;
   localparam int CFG_ROT = 6;
   localparam int CFG_ABS = 7;
   localparam int CFG_W = 8;

   // Status fields
   localparam int ST_BUSY = 0;
   localparam int ST_SERVO = 1;
   localparam int ST_HOMED = 2;
   localparam int ST_PC = 3;
   localparam int ST_ABSREF = 4;
   localparam int ST_SHORT = 5;
   localparam int ST_STATE = 8;

   // Reset values
   localparam logic [CFG_W-1:0] CFG_RST = 8'h01;
   localparam logic [31:0] HPOS_RST = 32'h0000_0000;
   localparam logic [31:0] HOFS_RST = 32'h0000_0000;
   localparam logic [15:0] SPEED_RST = 16'h0010;
   localparam logic [15:0] ACCEL_RST = 16'h0001;
   localparam logic [31:0] REV_RST = 32'h0000_1000;

   // Profile update period
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;

   typedef enum logic [1:0] {
      SEQ_IMM = 2'h0,
      SEQ_SW = 2'h1,
      SEQ_MRK = 2'h2,
      SEQ_SWMRK = 2'h3
   } ahs_seq_e;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_START = 4'h1,
      S_JOG = 4'h3,
      S_JMRK = 4'h2,
      S_PLAN = 4'h6,
      S_REV = 4'h7,
      S_MOVE = 4'h5,
      S_BRAKE = 4'h4,
      S_PWAIT = 4'hc,
      S_PMRK = 4'hd
   } ahs_state_e;
endpackage

/* File: logic/ahs_evt_sync.sv */
`timescale 1ns/1ps
module ahs_evt_sync import ahs_pkg::*; #(
   parameter int N = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Pins and polarity
   input wire logic [N-1:0] pin,
   input wire logic [N-1:0] invert,
   // Events
   output logic [N-1:0] evt,
   output logic [N-1:0] lvl
);
   initial begin
      if (N < 1) $error("ahs_evt_sync: N must be at least 1");
   end

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_ch
         logic s1_ff, s2_ff, s3_ff, evt_ff;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
               evt_ff <= 1'b0;
            end else if (ce) begin
               s1_ff <= pin[i];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff ^ invert[i];
               evt_ff <= (s2_ff ^ invert[i]) & ~s3_ff;
            end
         end
         assign evt[i] = evt_ff;
         assign lvl[i] = s3_ff;
      end
   endgenerate
endmodule // ahs_evt_sync

/* File: logic/ahs_homing.sv */
`timescale 1ns/1ps
//Contract
//- Accept mode, sequence, home position, offset, direction and speed.
//- A config bit picks normally open or normally closed home switch.
//- With absolute feedback every completed homing sets absolute reference.
//- Active request enables servo, cancels motion, clears motion status.
//- Active homing motion follows a trapezoidal velocity profile.
//- Sequences immediate, switch, marker, switch-marker; non-immediate jog toward event.
//- After home event, redefine position then move to home position.
//- Unidirectional homing never reverses travel on the move to home.
//- Non-rotary unidirectional short offset: decelerate to stop, no process complete.
//- Rotary short offset: add whole revolutions to keep move unidirectional.
//- Rotary short offset: target unwind zero from the home event.
//- Passive redefines position at next marker or switch, commands no motion.
//- Closed-loop passive uses immediate: position set to home, no motion.
//- Switch-then-marker keeps homing speed from switch until marker.
//- Completion sets the axis-homed status bit.
module ahs_homing import ahs_pkg::*; (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Sensor pins
   input wire logic MARKER,
   input wire logic HOME_SW,
   // Axis feedback
   input wire logic signed [31:0] ACT_POS,
   // Axis control
   output logic SERVO_EN,
   output logic MOTION_CANCEL,
   output logic signed [31:0] CMD_VEL,
   output logic POS_LOAD,
   output logic signed [31:0] POS_LOAD_VAL,
   output logic ABS_REF_SET,
   // Status
   output logic HOME_DONE,
   output logic HOMED,
   output logic PROC_COMPLETE,
   output logic BUSY
);
   ahs_state_e state_ff, nxt_state;

   logic [CFG_W-1:0] cfg_ff;
   logic signed [31:0] hpos_ff, hofs_ff, rev_ff;
   logic [15:0] speed_ff, accel_ff;
   logic hold_ff;
   logic [31:0] prdata_ff, rd_mux;
   logic rd_hit, wr_en;

   logic servo_ff, cancel_ff, load_ff, absset_ff, done_ff;
   logic homed_ff, pc_ff, absref_ff, short_ff;
   logic signed [31:0] load_val_ff, tgt_ff, dist_ff;
   logic signed [31:0] cmd_vel_ff;
   logic mdir_ff;
   logic [$clog2(TICK_CYC)-1:0] tick_cnt_ff;
   logic tick;

   logic start, servo_off;
   logic active, dir, uni, rot;
   ahs_seq_e seq;
   logic sw_evt, mk_evt;
   logic [1:0] evt, lvl;
   logic home_evt, sw_first;
   logic signed [31:0] ofs_dir, rem, evt_pos;
   logic [15:0] vel;
   logic braking, run, move;
   logic [48:0] need_dist;
   logic [31:0] vsq;
   logic short_now, finish, finish_short;

   assign active = cfg_ff[CFG_ACTIVE];
   assign seq = ahs_seq_e'(cfg_ff[CFG_SEQ +: 2]);
   assign dir = cfg_ff[CFG_DIR];
   assign uni = cfg_ff[CFG_UNI];
   assign rot = cfg_ff[CFG_ROT];

   // APB: always ready one cycle after setup, unless frozen
   assign PREADY = PSEL & PENABLE & hold_ff & CE;
   assign wr_en = PREADY & PWRITE & rd_hit;
   assign PSLVERR = PREADY & ~rd_hit;
   assign PRDATA = prdata_ff;
   assign start = wr_en & (PADDR == OFS_CTRL) & PWDATA[CTRL_START];
   assign servo_off = wr_en & (PADDR == OFS_CTRL) & PWDATA[CTRL_SERVO_OFF];

   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (PADDR)
         OFS_CTRL: rd_mux = 32'h0000_0000;
         OFS_CFG: rd_mux[CFG_W-1:0] = cfg_ff;
         OFS_HPOS: rd_mux = hpos_ff;
         OFS_HOFS: rd_mux = hofs_ff;
         OFS_SPEED: rd_mux[15:0] = speed_ff;
         OFS_ACCEL: rd_mux[15:0] = accel_ff;
         OFS_REV: rd_mux = rev_ff;
         OFS_STAT: begin
            rd_mux[ST_BUSY] = BUSY;
            rd_mux[ST_SERVO] = servo_ff;
            rd_mux[ST_HOMED] = homed_ff;
            rd_mux[ST_PC] = pc_ff;
            rd_mux[ST_ABSREF] = absref_ff;
            rd_mux[ST_SHORT] = short_ff;
            rd_mux[ST_STATE +: 4] = state_ff;
         end
         OFS_POS: rd_mux = ACT_POS;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         hold_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else if (CE) begin
         hold_ff <= PSEL & ~PREADY;
         if (PSEL && !PREADY) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   // Configuration is held while a sequence runs to keep it coherent
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cfg_ff <= CFG_RST;
         hpos_ff <= HPOS_RST;
         hofs_ff <= HOFS_RST;
         speed_ff <= SPEED_RST;
         accel_ff <= ACCEL_RST;
         rev_ff <= REV_RST;
      end else if (CE && wr_en && state_ff == S_IDLE) begin
         case (PADDR)
            OFS_CFG: cfg_ff <= PWDATA[CFG_W-1:0];
            OFS_HPOS: hpos_ff <= PWDATA;
            OFS_HOFS: hofs_ff <= PWDATA;
            OFS_SPEED: speed_ff <= PWDATA[15:0];
            OFS_ACCEL: accel_ff <= PWDATA[15:0];
            OFS_REV: rev_ff <= PWDATA;
            default: ;
         endcase
      end
   end

   ahs_evt_sync #(.N(2)) u_sync (
      .clk(MCLK),
      .rst(RST),
      .ce(CE),
      .pin({HOME_SW, MARKER}),
      .invert({cfg_ff[CFG_NC], 1'b0}),
      .evt(evt),
      .lvl(lvl)
   );
   assign mk_evt = evt[0];
   assign sw_evt = evt[1];

   assign home_evt = (seq == SEQ_SW) ? sw_evt : mk_evt;
   assign sw_first = (seq == SEQ_SWMRK) & sw_evt;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         tick_cnt_ff <= '0;
      end else if (CE) begin
         if (tick) begin
            tick_cnt_ff <= '0;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
         end
      end
   end
   assign tick = (tick_cnt_ff == ($clog2(TICK_CYC))'(TICK_CYC - 1));

   // Offset measured along the home direction
   assign ofs_dir = dir ? -hofs_ff : hofs_ff;
   assign evt_pos = hpos_ff - hofs_ff;
   assign rem = mdir_ff ? ACT_POS - tgt_ff : tgt_ff - ACT_POS;
   assign vsq = vel * vel;
   assign need_dist = {accel_ff, 1'b0} * $unsigned(dist_ff);
   assign short_now = uni & (dist_ff < 32'sd0 | need_dist < {17'h0_0000, vsq});

   assign run = state_ff == S_JOG || state_ff == S_JMRK || state_ff == S_PLAN
      || state_ff == S_REV || state_ff == S_MOVE;
   assign move = state_ff == S_MOVE;

   ahs_trap u_trap (
      .clk(MCLK),
      .rst(RST),
      .ce(CE),
      .tick(tick),
      .run(run),
      .move(move),
      .vmax(speed_ff),
      .accel(accel_ff),
      .rem(move ? rem : 32'sd0),
      .vel(vel),
      .braking(braking)
   );

   assign finish = (state_ff == S_MOVE && vel == 16'h0000 && rem <= 32'sd0)
      || ((state_ff == S_START || state_ff == S_IDLE) && nxt_state == S_IDLE
         && load_ff == 1'b0 && start_ok())
      || ((state_ff == S_PWAIT || state_ff == S_PMRK) && nxt_state == S_IDLE);
   assign finish_short = state_ff == S_BRAKE && vel == 16'h0000 && short_ff;

   function automatic logic start_ok();
      start_ok = (state_ff == S_IDLE) ? (start & ~active & seq == SEQ_IMM)
         : (seq == SEQ_IMM);
   endfunction

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (start) begin
               if (active) begin
                  nxt_state = S_START;
               end else if (seq != SEQ_IMM) begin
                  nxt_state = S_PWAIT;
               end
            end
         end
         S_START: nxt_state = (seq == SEQ_IMM) ? S_IDLE : S_JOG;
         S_JOG: begin
            if (sw_first) begin
               nxt_state = S_JMRK;
            end else if (seq != SEQ_SWMRK && home_evt) begin
               nxt_state = S_PLAN;
            end
         end
         S_JMRK: if (mk_evt) nxt_state = S_PLAN;
         S_PLAN: begin
            if (!uni && dist_ff < 32'sd0) begin
               nxt_state = S_BRAKE;
            end else if (!short_now) begin
               nxt_state = S_MOVE;
            end else if (rot) begin
               nxt_state = S_REV;
            end else begin
               nxt_state = S_BRAKE;
            end
         end
         S_REV: if (!short_now) nxt_state = S_MOVE;
         S_MOVE: if (vel == 16'h0000 && rem <= 32'sd0) nxt_state = S_IDLE;
         S_BRAKE: begin
            if (vel == 16'h0000) nxt_state = short_ff ? S_IDLE : S_MOVE;
         end
         S_PWAIT: begin
            if (sw_first) begin
               nxt_state = S_PMRK;
            end else if (seq != SEQ_SWMRK && home_evt) begin
               nxt_state = S_IDLE;
            end
         end
         S_PMRK: if (mk_evt) nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_ff <= S_IDLE;
      end else if (CE) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         servo_ff <= 1'b0;
         cancel_ff <= 1'b0;
      end else if (CE) begin
         cancel_ff <= start & active & state_ff == S_IDLE;
         if (start && active && state_ff == S_IDLE) begin
            servo_ff <= 1'b1;
         end else if (servo_off && state_ff == S_IDLE) begin
            servo_ff <= 1'b0;
         end
      end
   end

   // Position redefinition
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         load_ff <= 1'b0;
         load_val_ff <= 32'sd0;
      end else if (CE) begin
         load_ff <= 1'b0;
         if ((state_ff == S_IDLE && start && !active && seq == SEQ_IMM)
            || (state_ff == S_START && seq == SEQ_IMM)) begin
            load_ff <= 1'b1;
            load_val_ff <= hpos_ff;
         end else if ((state_ff == S_JOG && seq != SEQ_SWMRK && home_evt)
            || (state_ff == S_JMRK && mk_evt)) begin
            load_ff <= 1'b1;
            load_val_ff <= evt_pos;
         end else if ((state_ff == S_PWAIT && seq != SEQ_SWMRK && home_evt)
            || (state_ff == S_PMRK && mk_evt)) begin
            load_ff <= 1'b1;
            load_val_ff <= evt_pos;
         end
      end
   end

   // Move planning
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         dist_ff <= 32'sd0;
         tgt_ff <= 32'sd0;
         mdir_ff <= 1'b0;
         short_ff <= 1'b0;
      end else if (CE) begin
         if (state_ff == S_START) begin
            mdir_ff <= dir;
            short_ff <= 1'b0;
         end
         if (nxt_state == S_PLAN && state_ff != S_PLAN) begin
            dist_ff <= ofs_dir;
         end
         if (state_ff == S_REV && short_now) begin
            dist_ff <= dist_ff + rev_ff;
         end
         if (state_ff == S_PLAN) begin
            if (rot && uni && short_now) begin
               tgt_ff <= load_val_ff;
            end else begin
               tgt_ff <= hpos_ff;
            end
            short_ff <= uni & short_now & ~rot;
         end
         if (state_ff == S_REV && !short_now) begin
            tgt_ff <= dir ? tgt_ff - dist_ff : tgt_ff + dist_ff;
         end
         if (state_ff == S_BRAKE && vel == 16'h0000 && !short_ff) begin
            mdir_ff <= ~dir;
         end
      end
   end

   // Signed velocity command
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cmd_vel_ff <= 32'sd0;
      end else if (CE) begin
         cmd_vel_ff <= mdir_ff ? -$signed({16'h0000, vel}) : $signed({16'h0000, vel});
      end
   end

   // Completion status; a start clears, completion sets
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         done_ff <= 1'b0;
         absset_ff <= 1'b0;
         homed_ff <= 1'b0;
         pc_ff <= 1'b0;
         absref_ff <= 1'b0;
      end else if (CE) begin
         done_ff <= finish;
         absset_ff <= finish & cfg_ff[CFG_ABS];
         if (finish) begin
            homed_ff <= 1'b1;
            pc_ff <= 1'b1;
            if (cfg_ff[CFG_ABS]) absref_ff <= 1'b1;
         end else if (start && state_ff == S_IDLE) begin
            homed_ff <= 1'b0;
            pc_ff <= 1'b0;
            absref_ff <= 1'b0;
         end
      end
   end

   assign SERVO_EN = servo_ff;
   assign MOTION_CANCEL = cancel_ff;
   assign CMD_VEL = cmd_vel_ff;
   assign POS_LOAD = load_ff;
   assign POS_LOAD_VAL = load_val_ff;
   assign ABS_REF_SET = absset_ff;
   assign HOME_DONE = done_ff;
   assign HOMED = homed_ff;
   assign PROC_COMPLETE = pc_ff;
   assign BUSY = state_ff != S_IDLE;
   // Short stop ends silently in idle with the short flag set
   logic unused_ok;
   assign unused_ok = finish_short & braking & lvl[0] & lvl[1];
endmodule // ahs_homing

/* File: logic/ahs_trap.sv */
`timescale 1ns/1ps
module ahs_trap import ahs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic tick,
   input wire logic run,
   input wire logic move,
   input wire logic [15:0] vmax,
   input wire logic [15:0] accel,
   input wire logic signed [31:0] rem,
   // Profile
   output logic [15:0] vel,
   output logic braking
);
   logic [15:0] vel_ff;
   logic [31:0] vsq;
   logic [48:0] need;

   assign vsq = vel_ff * vel_ff;
   assign need = {accel, 1'b0} * $unsigned(rem);
   // Stop distance v^2/2a reached: start ramping down
   assign braking = move & (rem <= 32'sd0 | need <= {17'h0_0000, vsq});
   assign vel = vel_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vel_ff <= 16'h0000;
      end else if (ce && tick) begin
         if (!run || braking || vel_ff > vmax) begin
            vel_ff <= (vel_ff > accel) ? vel_ff - accel : 16'h0000;
         end else if (vmax - vel_ff > accel) begin
            vel_ff <= vel_ff + accel;
         end else begin
            vel_ff <= vmax;
         end
      end
   end
endmodule // ahs_trap

/* File: sim/ahs_axis_model.sv */
`timescale 1ns/1ps
module ahs_axis_model import ahs_pkg::*; #(
   parameter int SW_LO = 300,
   parameter int SW_HI = 400
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Commands
   input wire logic servo_en,
   input wire logic signed [31:0] cmd_vel,
   input wire logic signed [31:0] ext_vel,
   input wire logic pos_load,
   input wire logic signed [31:0] pos_load_val,
   input wire logic nc,
   // Sensors and feedback
   output logic signed [31:0] act_pos,
   output logic marker,
   output logic home_sw
);
   logic signed [31:0] phys_ff, ofs_ff, nxt_phys;
   int tick_ff;
   assign nxt_phys = phys_ff + (servo_en ? cmd_vel : 32'sh0) + ext_vel;
   assign act_pos = phys_ff + ofs_ff;
   assign home_sw = (phys_ff >= SW_LO && phys_ff < SW_HI) ^ nc;
   // Marker stays high one tick per 256-count crossing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phys_ff <= '0;
         tick_ff <= 0;
         marker <= 1'b0;
      end else if (tick_ff == TICK_CYC - 1) begin
         tick_ff <= 0;
         phys_ff <= nxt_phys;
         marker <= (nxt_phys >>> 8) != (phys_ff >>> 8);
      end else begin
         tick_ff <= tick_ff + 1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ofs_ff <= '0;
      else if (pos_load) ofs_ff <= pos_load_val - phys_ff;
   end
endmodule // ahs_axis_model

/* File: sim/ahs_homing_monitor.sv */
`timescale 1ns/1ps
module ahs_homing_monitor import ahs_pkg::*; (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   // Register bus
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Axis and status
   input wire logic SERVO_EN,
   input wire logic MOTION_CANCEL,
   input wire logic signed [31:0] CMD_VEL,
   input wire logic POS_LOAD,
   input wire logic signed [31:0] POS_LOAD_VAL,
   input wire logic ABS_REF_SET,
   input wire logic HOME_DONE,
   input wire logic HOMED,
   input wire logic PROC_COMPLETE,
   input wire logic BUSY
);
   logic [CFG_W-1:0] cfg_ff;
   logic [31:0] hpos_ff;
   logic wr_ok;
   logic start;
   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !BUSY;
   assign start = wr_ok && PADDR == OFS_CTRL && PWDATA[CTRL_START];
   // Shadow copies; the block drops these writes while busy as well
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) cfg_ff <= CFG_RST;
      else if (wr_ok && PADDR == OFS_CFG) cfg_ff <= PWDATA[CFG_W-1:0];
   end
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) hpos_ff <= HPOS_RST;
      else if (wr_ok && PADDR == OFS_HPOS) hpos_ff <= PWDATA;
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   a_err_unmapped:
      assert property (PSEL && PENABLE && PREADY && (PADDR > OFS_POS || PADDR[1:0] != 2'h0)
         |-> PSLVERR)
      else $error("bad address not refused");
   a_ready_prompt:
      assert property (PSEL && !PENABLE && CE ##1 PSEL && PENABLE && CE |-> PREADY)
      else $error("access phase not answered");
   a_start_servo:
      assert property (start && cfg_ff[CFG_ACTIVE] |=> SERVO_EN && MOTION_CANCEL)
      else $error("active start without servo and cancel");
   a_cancel_once:
      assert property (MOTION_CANCEL && CE |=> !MOTION_CANCEL [*2])
      else $error("cancel longer than one cycle");
   a_imm_load:
      assert property (start && !cfg_ff[CFG_ACTIVE] && cfg_ff[2:1] == SEQ_IMM
         |=> POS_LOAD && HOME_DONE && POS_LOAD_VAL == hpos_ff)
      else $error("immediate home did not load position");
   a_passive_still:
      assert property (BUSY && !cfg_ff[CFG_ACTIVE] |-> CMD_VEL == 0)
      else $error("passive homing commanded motion");
   a_uni_travel:
      assert property (BUSY && cfg_ff[CFG_ACTIVE] && cfg_ff[CFG_UNI]
         |-> (cfg_ff[CFG_DIR] ? CMD_VEL <= 0 : CMD_VEL >= 0))
      else $error("unidirectional homing reversed");
   a_done_status:
      assert property (HOME_DONE |-> HOMED && PROC_COMPLETE)
      else $error("done without homed status");
   a_done_pulse:
      assert property (HOME_DONE && CE |=> !HOME_DONE)
      else $error("done pulse too long");
   a_absref_done:
      assert property (ABS_REF_SET |-> HOME_DONE && cfg_ff[CFG_ABS])
      else $error("absolute reference out of place");
   a_load_once:
      assert property (POS_LOAD && CE |=> !POS_LOAD)
      else $error("position load repeated");
endmodule // ahs_homing_monitor
bind ahs_homing ahs_homing_monitor ahs_homing_monitor_i (.MCLK, .RST, .CE, .PSEL, .PENABLE,
   .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .SERVO_EN, .MOTION_CANCEL, .CMD_VEL,
   .POS_LOAD, .POS_LOAD_VAL, .ABS_REF_SET, .HOME_DONE, .HOMED, .PROC_COMPLETE, .BUSY);

/* File: sim/ahs_homing_tb.sv */
`timescale 1ns/1ps
module ahs_homing_tb import ahs_pkg::*;;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, marker, home_sw, nc, e, x;
   logic servo_en, cancel, pos_load, abs_ref, home_done, homed, proc_done, busy;
   logic [7:0] paddr, a;
   logic [31:0] pwdata, prdata, r, rs, w;
   logic signed [31:0] act_pos, cmd_vel, load_val, ext_vel, prev_vel;
   int err_count, samples_checked, done_cnt, abs_cnt, neg_cnt, pos_cnt, jump_cnt;
   logic [72:0] rows [8];
   ahs_homing ahs_homing_i (.MCLK(mclk), .RST(rst), .CE(1'b1), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .MARKER(marker), .HOME_SW(home_sw),
      .ACT_POS(act_pos), .SERVO_EN(servo_en), .MOTION_CANCEL(cancel), .CMD_VEL(cmd_vel),
      .POS_LOAD(pos_load), .POS_LOAD_VAL(load_val), .ABS_REF_SET(abs_ref),
      .HOME_DONE(home_done), .HOMED(homed), .PROC_COMPLETE(proc_done), .BUSY(busy));
   ahs_axis_model ahs_axis_model_i (.clk(mclk), .rst(rst), .servo_en(servo_en),
      .cmd_vel(cmd_vel), .ext_vel(ext_vel), .pos_load(pos_load), .pos_load_val(load_val),
      .nc(nc), .act_pos(act_pos), .marker(marker), .home_sw(home_sw));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Pulse counts and a coarse profile watch, acceleration is 4 per tick
   always @(posedge mclk) begin
      done_cnt += int'(home_done === 1'b1);
      abs_cnt += int'(abs_ref === 1'b1);
      pos_cnt += int'(cmd_vel > 0);
      neg_cnt += int'(cmd_vel < 0);
      jump_cnt += int'(cmd_vel - prev_vel > 4 || prev_vel - cmd_vel > 4);
      prev_vel = cmd_vel;
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Ready is looked at mid-cycle, where it has settled; the request stands until that edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(negedge mclk);
      while (pready !== 1'b1) begin
         @(negedge mclk);
      end
      r = prdata;
      e = pslverr;
      @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      @(posedge mclk);
      while (busy !== 1'b0 && n < 30000) begin
         n++;
         @(posedge mclk);
      end
      repeat (2) @(posedge mclk);
      chk("idle wait", 32'(n < 30000), 1);
   endtask
   task automatic finish_test;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge mclk);
      err_count++;
      finish_test();
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, nc, ext_vel, prev_vel} = '0;
      rst = 1'b1;
      // Address, reset value, write value, refused
      rows = '{{OFS_CFG, 32'h1, 32'h83, 1'b0}, {OFS_HPOS, 32'h0, 32'h40, 1'b0},
         {OFS_HOFS, 32'h0, 32'hc8, 1'b0}, {OFS_SPEED, 32'h10, 32'h10, 1'b0},
         {OFS_ACCEL, 32'h1, 32'h4, 1'b0}, {OFS_REV, 32'h1000, 32'h100, 1'b0},
         {8'h24, 32'h0, 32'h5a, 1'b1}, {8'h06, 32'h0, 32'ha5, 1'b1}};
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      chk("reset outputs", {busy, servo_en, homed, proc_done}, 0);
      foreach (rows[i]) begin
         {a, rs, w, x} = rows[i];
         apb(1'b0, a, 0);
         chk("reset value", r, rs);
         apb(1'b1, a, w);
         chk("write refusal", e, x);
         apb(1'b0, a, 0);
         chk("read back", r, x ? 32'h0 : w);
      end
      $display("test registers done");
      apb(1'b1, OFS_CTRL, 32'h1);
      wait_idle();
      chk("done count", done_cnt, 1);
      chk("status", {homed, proc_done, servo_en}, 3'b111);
      chk("abs reference", abs_cnt, 1);
      chk("event load", load_val, 32'h40 - 32'hc8);
      chk("reverse ticks", neg_cnt, 0);
      chk("profile steps", jump_cnt, 0);
      apb(1'b0, OFS_POS, 0);
      chk("home reached", 32'(r - 32'h20 < 32'h40), 1);
      $display("test active switch done");
      nc <= 1'b1;
      apb(1'b1, OFS_CFG, 32'h1b);
      apb(1'b1, OFS_CTRL, 32'h1);
      wait_idle();
      chk("closed switch done", done_cnt, 2);
      $display("test closed switch done");
      nc <= 1'b0;
      apb(1'b1, OFS_CFG, 32'h0);
      apb(1'b1, OFS_HPOS, 32'h1234);
      apb(1'b1, OFS_CTRL, 32'h1);
      wait_idle();
      apb(1'b0, OFS_POS, 0);
      chk("immediate position", r, 32'h1234);
      chk("immediate done", done_cnt, 3);
      $display("test passive immediate done");
      apb(1'b1, OFS_CFG, 32'h4);
      apb(1'b1, OFS_CTRL, 32'h1);
      ext_vel <= 32'sd8;
      wait_idle();
      ext_vel <= 32'sd0;
      chk("marker load", load_val, 32'h1234 - 32'hc8);
      chk("marker done", done_cnt, 4);
      $display("test passive marker done");
      apb(1'b1, OFS_HOFS, 32'h2);
      apb(1'b1, OFS_CFG, 32'h25);
      neg_cnt = 0;
      apb(1'b1, OFS_CTRL, 32'h1);
      wait_idle();
      chk("short done", done_cnt, 4);
      chk("short status", {homed, proc_done}, 0);
      chk("short reverse", neg_cnt, 0);
      $display("test short offset done");
      // multi-turn axis uses switch then marker
      apb(1'b1, OFS_CFG, 32'h6f);
      pos_cnt = 0;
      apb(1'b1, OFS_CTRL, 32'h1);
      wait_idle();
      chk("rotary done", done_cnt, 5);
      chk("rotary complete", proc_done, 1);
      chk("rotary reverse", pos_cnt, 0);
      $display("test rotary short done");
      finish_test();
   end
endmodule // ahs_homing_tb
